// File: otl_pkg.sv
// How it works
// - At rest, attitude is classified into one of six axis orientations.
// - Portrait output is high from acceptance of a portrait orientation until another one is accepted or the device leaves run mode.
// - Landscape output is high from acceptance of a landscape orientation until another one is accepted or the device leaves run mode.
// - Sign output separates opposite portrait, landscape and face orientations.
// - Sleep input low selects power-down, high selects normal; device follows it.
// - In power-down the measurement chain stops and no new detections occur.
// - After power-down release, outputs are valid only after a 30 ms turn-on time.
// - When enabled, a tap along the z axis raises the interrupt.
// - Optionally a second tap inside a programmable window reports a double tap.
// - A self-test injects a stimulus to check sensing without motion.
package otl_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned TON_MS = 30;
  localparam int unsigned TON_CYC = TON_MS * (CLK_HZ / 1000);
  localparam int unsigned STEADY_CYC = 16;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
  localparam logic [11:0] ADDR_IRQ_EN = 12'h00c;
  localparam logic [11:0] ADDR_IRQ_CLR = 12'h010;
  localparam logic [11:0] ADDR_TAP_THR = 12'h014;
  localparam logic [11:0] ADDR_DBL_WIN = 12'h018;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [15:0] TAP_THR_RST = 16'h2000;
  localparam logic [23:0] DBL_WIN_RST = 24'h0f4240;
  localparam logic [15:0] ORI_THR = 16'h3000;
  localparam logic [15:0] ST_OFFSET = 16'h1000;
  localparam int IRQ_TAP = 0;
  localparam int IRQ_DBL = 1;
  localparam int IRQ_ORI = 2;
  localparam int IRQ_RDY = 3;
  typedef enum logic [1:0] {
    OTL_SLEEP = 2'b00,
    OTL_WAKE = 2'b01,
    OTL_RUN = 2'b10
  } otl_mode_t;
endpackage : otl_pkg

// File: otl_classify.sv
module otl_classify
  import otl_pkg::*;
(
  input wire logic [15:0] acc_x,
  input wire logic [15:0] acc_y,
  input wire logic [15:0] acc_z,
  output logic [2:0] ori_code,
  output logic ori_hit
);
  logic [15:0] mag [3];
  logic neg [3];
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_ax
      logic [15:0] a;
      assign a = (i == 0) ? acc_x : ((i == 1) ? acc_y : acc_z);
      assign neg[i] = a[15];
      assign mag[i] = a[15] ? 16'(~a + 16'h0001) : a;
    end
  endgenerate
  // Code: bit2..1 axis (0 portrait y, 1 landscape x, 2 face z), bit0 sign
  always_comb begin
    ori_code = 3'h0;
    ori_hit = 1'b0;
    if (mag[1] > ORI_THR && mag[0] < ORI_THR && mag[2] < ORI_THR) begin
      ori_code = {2'b00, neg[1]};
      ori_hit = 1'b1;
    end else if (mag[0] > ORI_THR && mag[1] < ORI_THR && mag[2] < ORI_THR) begin
      ori_code = {2'b01, neg[0]};
      ori_hit = 1'b1;
    end else if (mag[2] > ORI_THR && mag[0] < ORI_THR && mag[1] < ORI_THR) begin
      ori_code = {2'b10, neg[2]};
      ori_hit = 1'b1;
    end
  end
endmodule : otl_classify

// File: otl_top.sv
module otl_top
  import otl_pkg::*;
#(
  parameter int unsigned TON_CYCLES = TON_CYC
)
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic sleep_n,
  input wire logic [15:0] acc_x,
  input wire logic [15:0] acc_y,
  input wire logic [15:0] acc_z,
  input wire logic acc_valid,
  output logic portrait_flag,
  output logic landscape_flag,
  output logic sign_flag,
  output logic tap_irq,
  output logic meas_en,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic [1:0] rst_sync_q;
  logic rst_n;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    otl_mode_t mode;
    logic [31:0] ton_cnt;
    logic [3:0] ctrl;
    logic [15:0] tap_thr;
    logic [23:0] dbl_win;
    logic [3:0] irq_stat;
    logic [3:0] irq_en;
    logic [2:0] cand;
    logic [4:0] steady;
    logic [2:0] ori;
    logic ori_ok;
    logic portrait;
    logic landscape;
    logic sign;
    logic irq;
    logic meas;
    logic [15:0] prev_z;
    logic tap_arm;
    logic [23:0] win_cnt;
    logic win_open;
    logic awready;
    logic wready;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic arready;
  } otl_state_t;

  localparam otl_state_t ST_RST = '{
    mode: OTL_SLEEP, ton_cnt: 32'h0, ctrl: CTRL_RST, tap_thr: TAP_THR_RST, dbl_win: DBL_WIN_RST,
    irq_stat: 4'h0, irq_en: 4'h0, cand: 3'h0, steady: 5'h0, ori: 3'h0, ori_ok: 1'b0,
    portrait: 1'b0, landscape: 1'b0, sign: 1'b0, irq: 1'b0, meas: 1'b0, prev_z: 16'h0,
    tap_arm: 1'b1, win_cnt: 24'h0, win_open: 1'b0, awready: 1'b1, wready: 1'b1,
    awaddr: 12'h0, wdata: 32'h0, wstrb: 4'h0, bvalid: 1'b0, bresp: 2'h0, rvalid: 1'b0,
    rdata: 32'h0, rresp: 2'h0, arready: 1'b1};

  otl_state_t s_q, s_d;

  // ctrl bits: 0 tap irq enable, 1 double tap enable, 2 self-test, 3 unused
  logic [15:0] st_z;
  logic [15:0] dz;
  logic [15:0] dz_mag;
  logic [2:0] ori_code;
  logic ori_hit;
  logic sample;
  logic tap_ev;
  logic [3:0] ev;
  logic aw_fire, w_fire, ar_fire;

  // Self-test adds a fixed offset to z so the chain sees a stimulus
  assign st_z = s_q.ctrl[2] ? 16'(acc_z + ST_OFFSET) : acc_z;

  otl_classify u_cls (
    .acc_x(acc_x),
    .acc_y(acc_y),
    .acc_z(st_z),
    .ori_code(ori_code),
    .ori_hit(ori_hit)
  );

  assign dz = 16'(st_z - s_q.prev_z);
  assign dz_mag = dz[15] ? 16'(~dz + 16'h0001) : dz;
  assign sample = acc_valid && (s_q.mode == OTL_RUN);
  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire = s_axi_wvalid && s_axi_wready;
  assign ar_fire = s_axi_arvalid && s_axi_arready;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d = s_q;
    tap_ev = 1'b0;
    ev = 4'h0;
    // Power mode follows the sleep pin
    unique case (s_q.mode)
      OTL_SLEEP: begin
        if (sleep_n) begin
          s_d.mode = OTL_WAKE;
          s_d.ton_cnt = 32'h0;
        end
      end
      OTL_WAKE: begin
        if (!sleep_n) begin
          s_d.mode = OTL_SLEEP;
        end else if (s_q.ton_cnt >= 32'(TON_CYCLES - 1)) begin
          s_d.mode = OTL_RUN;
          ev[IRQ_RDY] = 1'b1;
        end else begin
          s_d.ton_cnt = s_q.ton_cnt + 32'h1;
        end
      end
      OTL_RUN: begin
        if (!sleep_n) begin
          s_d.mode = OTL_SLEEP;
        end
      end
    endcase
    s_d.meas = (s_d.mode != OTL_SLEEP);
    if (s_d.mode != OTL_RUN) begin
      s_d.ori_ok = 1'b0;
      s_d.steady = 5'h0;
      s_d.win_open = 1'b0;
      s_d.tap_arm = 1'b1;
    end
    // Orientation: accept only after a steady run of samples
    if (sample) begin
      s_d.prev_z = st_z;
      if (!ori_hit || ori_code != s_q.cand) begin
        s_d.cand = ori_code;
        s_d.steady = 5'h0;
      end else if (s_q.steady < 5'(STEADY_CYC)) begin
        s_d.steady = s_q.steady + 5'h1;
      end else if (!s_q.ori_ok || s_q.ori != s_q.cand) begin
        s_d.ori = s_q.cand;
        s_d.ori_ok = 1'b1;
        ev[IRQ_ORI] = 1'b1;
      end
      // Tap: jerk on z above threshold, rearm when it falls back
      if (dz_mag > s_q.tap_thr) begin
        if (s_q.tap_arm) begin
          tap_ev = 1'b1;
        end
        s_d.tap_arm = 1'b0;
      end else begin
        s_d.tap_arm = 1'b1;
      end
    end
    if (s_q.win_open && s_q.mode == OTL_RUN) begin
      if (s_q.win_cnt == 24'h0) begin
        s_d.win_open = 1'b0;
      end else begin
        s_d.win_cnt = s_q.win_cnt - 24'h1;
      end
    end
    if (tap_ev) begin
      ev[IRQ_TAP] = s_q.ctrl[0];
      if (s_q.ctrl[1] && s_q.win_open) begin
        ev[IRQ_DBL] = 1'b1;
        s_d.win_open = 1'b0;
      end else if (s_q.ctrl[1]) begin
        s_d.win_open = 1'b1;
        s_d.win_cnt = s_q.dbl_win;
      end
    end
    s_d.portrait = s_d.ori_ok && (s_d.ori[2:1] == 2'b00);
    s_d.landscape = s_d.ori_ok && (s_d.ori[2:1] == 2'b01);
    s_d.sign = s_d.ori_ok && s_d.ori[0];
    // Bus write
    if (aw_fire) begin
      s_d.awready = 1'b0;
      s_d.awaddr = s_axi_awaddr;
    end
    if (w_fire) begin
      s_d.wready = 1'b0;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (!s_q.awready && !s_q.wready && !s_q.bvalid) begin
      s_d.awready = 1'b1;
      s_d.wready = 1'b1;
      s_d.bvalid = 1'b1;
      s_d.bresp = 2'h0;
      unique case ({s_q.awaddr[11:2], 2'b00})
        ADDR_CTRL: begin
          if (s_q.wstrb[0]) s_d.ctrl = s_q.wdata[3:0];
        end
        ADDR_IRQ_EN: begin
          if (s_q.wstrb[0]) s_d.irq_en = s_q.wdata[3:0];
        end
        ADDR_IRQ_CLR: begin
          if (s_q.wstrb[0]) s_d.irq_stat = s_q.irq_stat & ~s_q.wdata[3:0];
        end
        ADDR_TAP_THR: begin
          if (s_q.wstrb[0]) s_d.tap_thr[7:0] = s_q.wdata[7:0];
          if (s_q.wstrb[1]) s_d.tap_thr[15:8] = s_q.wdata[15:8];
        end
        ADDR_DBL_WIN: begin
          if (s_q.wstrb[0]) s_d.dbl_win[7:0] = s_q.wdata[7:0];
          if (s_q.wstrb[1]) s_d.dbl_win[15:8] = s_q.wdata[15:8];
          if (s_q.wstrb[2]) s_d.dbl_win[23:16] = s_q.wdata[23:16];
        end
        ADDR_STAT, ADDR_IRQ_STAT: begin
        end
        default: begin
          s_d.bresp = 2'h2;
        end
      endcase
    end
    // Set wins over clear
    s_d.irq_stat = s_d.irq_stat | ev;
    s_d.irq = |(s_d.irq_stat & s_d.irq_en);
    // Bus read
    if (s_axi_rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (ar_fire) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = 2'h0;
      s_d.rdata = 32'h0;
      unique case ({s_axi_araddr[11:2], 2'b00})
        ADDR_CTRL: s_d.rdata = {28'h0, s_q.ctrl};
        ADDR_STAT: s_d.rdata = {24'h0, s_q.ori_ok, s_q.ori, s_q.sign, s_q.landscape, s_q.mode};
        ADDR_IRQ_STAT: s_d.rdata = {28'h0, s_q.irq_stat};
        ADDR_IRQ_EN: s_d.rdata = {28'h0, s_q.irq_en};
        ADDR_IRQ_CLR: s_d.rdata = 32'h0;
        ADDR_TAP_THR: s_d.rdata = {16'h0, s_q.tap_thr};
        ADDR_DBL_WIN: s_d.rdata = {8'h0, s_q.dbl_win};
        default: s_d.rresp = 2'h2;
      endcase
    end
    s_d.arready = !s_d.rvalid;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign portrait_flag = s_q.portrait;
  assign landscape_flag = s_q.landscape;
  assign sign_flag = s_q.sign;
  assign tap_irq = s_q.irq;
  assign meas_en = s_q.meas;
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
endmodule : otl_top

// File: otl_properties.sv
module otl_properties #(
  parameter int unsigned TON_CYCLES = 20
)
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic sleep_n,
  input wire logic portrait_flag,
  input wire logic landscape_flag,
  input wire logic sign_flag,
  input wire logic tap_irq,
  input wire logic meas_en,
  input wire logic s_axi_bvalid
);
  logic [31:0] on_q;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      on_q <= 32'h0;
    end else begin
      on_q <= sleep_n ? on_q + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////
  property p_one_axis; !(portrait_flag && landscape_flag); endproperty
  property p_port_rise; $rose(portrait_flag) |-> $past(meas_en); endproperty
  property p_land_rise; $rose(landscape_flag) |-> $past(meas_en); endproperty
  property p_sign_rise; $rose(sign_flag) |-> $past(meas_en); endproperty
  property p_wake; $rose(sleep_n) |-> ##[1:6] meas_en; endproperty
  property p_sleep_off; !sleep_n [*4] |-> !meas_en && !portrait_flag && !landscape_flag && !sign_flag; endproperty
  property p_turn_on; $rose(portrait_flag) || $rose(landscape_flag) || $rose(sign_flag) |-> on_q >= TON_CYCLES;
  endproperty
  property p_irq_hold; $fell(tap_irq) |-> s_axi_bvalid || $past(s_axi_bvalid); endproperty
  a_one_axis: assert property (p_one_axis) else $error("both axis flags high");
  a_port_rise: assert property (p_port_rise) else $error("portrait rose while off");
  a_land_rise: assert property (p_land_rise) else $error("landscape rose while off");
  a_sign_rise: assert property (p_sign_rise) else $error("sign rose while off");
  a_wake: assert property (p_wake) else $error("chain not powered after wake");
  a_sleep_off: assert property (p_sleep_off) else $error("outputs active in sleep");
  a_turn_on: assert property (p_turn_on) else $error("flag rose inside turn-on");
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped without write");
  c_port: cover property ($rose(portrait_flag));
  c_land: cover property ($rose(landscape_flag));
  c_tap: cover property ($rose(tap_irq));
endmodule : otl_properties

bind otl_top otl_properties #(.TON_CYCLES(TON_CYCLES)) i_props (.ref_clk(ref_clk), .arst_n(arst_n),
  .sleep_n(sleep_n), .portrait_flag(portrait_flag), .landscape_flag(landscape_flag), .sign_flag(sign_flag),
  .tap_irq(tap_irq), .meas_en(meas_en), .s_axi_bvalid(s_axi_bvalid));

// File: otl_host_model.sv
module otl_host_model #(
  parameter int unsigned TON_CYCLES = 20
)
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic wake,
  input wire logic portrait_flag,
  input wire logic landscape_flag,
  input wire logic sign_flag,
  output logic sleep_n,
  output logic out_valid,
  output logic [2:0] seen
);
  int unsigned wait_q;
  assign out_valid = sleep_n && (wait_q >= TON_CYCLES + 8);
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sleep_n <= 1'b0;
      wait_q <= 0;
      seen <= 3'h0;
    end else begin
      sleep_n <= wake;
      wait_q <= !sleep_n ? 0 : (out_valid ? wait_q : wait_q + 1);
      if (out_valid) begin
        seen <= {portrait_flag, landscape_flag, sign_flag};
      end
    end
  end
endmodule : otl_host_model

// File: testbench.sv
module testbench
  import otl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned TON = 20;
  logic ref_clk = 1'b0, arst_n = 1'b0, wake = 1'b0, acc_valid = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [15:0] acc_x = 16'h0000, acc_y = 16'h0000, acc_z = 16'h0000;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic sleep_n, portrait_flag, landscape_flag, sign_flag, tap_irq, meas_en, out_valid;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [2:0] seen;
  logic [15:0] zs [4] = '{16'h2000, 16'h4001, 16'h4001, 16'h2000};
  logic [31:0] es [4] = '{32'h0, 32'h1, 32'h1, 32'h3};
  int bad_count = 0;
  int n_compared = 0;
  always #2.5 ref_clk = ~ref_clk;
  otl_top #(.TON_CYCLES(TON)) i_dut (.ref_clk, .arst_n, .sleep_n, .acc_x, .acc_y, .acc_z, .acc_valid,
    .portrait_flag, .landscape_flag, .sign_flag, .tap_irq, .meas_en, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  otl_host_model #(.TON_CYCLES(TON)) i_host (.ref_clk, .arst_n, .wake, .portrait_flag, .landscape_flag,
    .sign_flag, .sleep_n, .out_valid, .seen);
  ////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("Compared %0d, bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  task automatic hang(input int n);
    if (n >= 60) begin
      chk(32'h0, 32'h1);
      tally_and_finish();
    end
  endtask : hang
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    n = 0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 60);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
    hang(n);
  endtask : wr
  task automatic rd_reg(input logic [11:0] a);
    int n;
    @(posedge ref_clk);
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 60);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    hang(n);
  endtask : rd_reg
  task automatic smp(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
    @(posedge ref_clk);
    acc_x <= x;
    acc_y <= y;
    acc_z <= z;
    acc_valid <= 1'b1;
    @(posedge ref_clk);
    acc_valid <= 1'b0;
  endtask : smp
  task automatic stat_is(input logic [31:0] m, input logic [31:0] e);
    rd_reg(ADDR_IRQ_STAT);
    chk(rd & m, e);
  endtask : stat_is
  task automatic wake_up;
    int n;
    wake <= 1'b1;
    for (n = 0; n < 200 && !out_valid; n++) tick(1);
    if (!out_valid) hang(60);
    rd_reg(ADDR_STAT);
    chk(rd & 32'h3, 32'h2);
    stat_is(32'h8, 32'h8);
  endtask : wake_up
  ////////////////////////////////////////////////////////////////
  initial begin
    int a;
    logic [15:0] v;
    tick(10);
    arst_n <= 1'b1;
    tick(5);
    rd_reg(ADDR_TAP_THR);
    chk(rd, {16'h0000, TAP_THR_RST});
    rd_reg(ADDR_DBL_WIN);
    chk(rd, {8'h00, DBL_WIN_RST});
    rd_reg(ADDR_CTRL);
    chk(rd, {28'h0, CTRL_RST});
    rd_reg(12'h100);
    chk({30'h0, rsp}, 32'h2);
    s_axi_wstrb <= 4'h1;
    wr(ADDR_TAP_THR, 32'h0000_55aa);
    chk({30'h0, rsp}, 32'h0);
    s_axi_wstrb <= 4'hf;
    rd_reg(ADDR_TAP_THR);
    chk(rd, {16'h0000, TAP_THR_RST[15:8], 8'haa});
    wr(ADDR_TAP_THR, {16'h0000, TAP_THR_RST});
    wr(12'h100, 32'h0);
    chk({30'h0, rsp}, 32'h2);
    wake_up();
    $display("Test reset and wake done");
    for (int i = 0; i < 6; i++) begin
      v = i[0] ? 16'hc000 : 16'h4000;
      a = i / 2;
      repeat (20) smp(a == 1 ? v : 16'h0000, a == 0 ? v : 16'h0000, a == 2 ? v : 16'h0000);
      tick(3);
      chk({29'h0, seen}, {29'h0, a == 0, a == 1, i[0]});
      rd_reg(ADDR_STAT);
      chk({28'h0, rd[7:4]}, {28'h0, 1'b1, a[1:0], i[0]});
    end
    stat_is(32'h4, 32'h4);
    $display("Test orientation done");
    repeat (2) smp(16'h0000, 16'h0000, 16'h0000);
    wr(ADDR_IRQ_CLR, 32'hf);
    wr(ADDR_IRQ_EN, 32'h3);
    wr(ADDR_CTRL, 32'h3);
    for (int k = 0; k < 4; k++) begin
      smp(16'h0000, 16'h0000, zs[k]);
      tick(2);
      chk({31'h0, tap_irq}, {31'h0, es[k] != 0});
      stat_is(32'h3, es[k]);
    end
    wr(ADDR_IRQ_EN, 32'h0);
    tick(2);
    chk({31'h0, tap_irq}, 32'h0);
    wr(ADDR_IRQ_EN, 32'h3);
    tick(2);
    chk({31'h0, tap_irq}, 32'h1);
    wr(ADDR_IRQ_CLR, 32'h3);
    tick(2);
    chk({31'h0, tap_irq}, 32'h0);
    rd_reg(ADDR_IRQ_CLR);
    chk(rd, 32'h0);
    wr(ADDR_DBL_WIN, 32'h4);
    smp(16'h0000, 16'h0000, 16'h2000);
    smp(16'h0000, 16'h0000, 16'h6001);
    smp(16'h0000, 16'h0000, 16'h6001);
    tick(10);
    smp(16'h0000, 16'h0000, 16'h2000);
    stat_is(32'h3, 32'h1);
    $display("Test tap done");
    wake <= 1'b0;
    tick(6);
    chk({28'h0, meas_en, portrait_flag, landscape_flag, sign_flag}, 32'h0);
    wr(ADDR_IRQ_CLR, 32'hf);
    smp(16'h0000, 16'h0000, 16'h4000);
    smp(16'h0000, 16'h0000, 16'h0000);
    stat_is(32'h3, 32'h0);
    wake_up();
    $display("Test sleep done");
    wr(ADDR_CTRL, 32'h4);
    repeat (20) smp(16'h0000, 16'h0000, 16'h2800);
    tick(3);
    chk({29'h0, seen}, 32'h0);
    rd_reg(ADDR_STAT);
    chk({28'h0, rd[7:4]}, 32'hc);
    $display("Test self check done");
    tally_and_finish();
  end
endmodule : testbench
